// ### hdl/mba_pkg.sv
// Purpose: shared constants and carriers for the burst adapter
// Assumes: one clock, byte addressing, lengths counted in beats
// Notes:   burst kinds follow the common fixed/incr/wrap coding
//==========================================================
// package
//==========================================================
package mba_pkg;
  localparam int          ADDR_W        = 32;
  localparam int          LEN_W         = 9;
  localparam int          SIZE_W        = 3;
  localparam logic [1:0]  BURST_FIXED   = 2'h0;
  localparam logic [1:0]  BURST_INCR    = 2'h1;
  localparam logic [1:0]  BURST_WRAP    = 2'h2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_EXOKAY   = 2'h1;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;
  localparam logic [8:0]  LEN_AXI4_MAX  = 9'h100;
  localparam logic [8:0]  LEN_AXI3_MAX  = 9'h010;
  localparam logic [8:0]  LEN_ONE       = 9'h001;
  localparam logic [8:0]  LEN_RST       = 9'h000;
  localparam logic [31:0] ADDR_RST      = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10,
    ST_RESP = 2'b11
  } mba_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  len;
    logic [SIZE_W-1:0] size;
    logic [1:0]        burst;
    logic              write;
  } mba_cmd_type;

  typedef struct packed {
    mba_state_type     state;
    mba_cmd_type       orig;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  left;
    logic [LEN_W-1:0]  piece;
    logic [1:0]        piece_burst;
    logic [LEN_W-1:0]  resp_left;
    logic [1:0]        resp;
    logic              lock;
    logic              tgt_valid;
    logic              ret_valid;
  } mba_state_vec_type;
endpackage : mba_pkg

// ### hdl/mba_adapter.sv
// Purpose: split and reshape initiator bursts into bursts the target accepts
// Assumes: target limits are elaboration parameters; one command at a time
// Notes:   responses come back one per piece, merged into one per burst
//
// Summary of operation
// - split long bursts; singles if no bursting
// - hold target lock for whole burst
// - lock span equals burst length, no shares
// - fixed burst becomes single beats, same address
// - length cap 256, or 16 for older target
// - unaligned start: single-beat pieces until aligned
// - handle wrap and sequential, mixed freely
// - default single generic converter
// - optional per-type converter path
// - incr to sequential: pass or split
// - incr to wrapping: no boundary crossing
// - wrap to sequential: respect own boundary
// - wrap to wrapping: pass if boundaries match
// - narrow bursts broken into single beats
// - native sequential to axi: max 16
// - native wrap to axi: wrap if short
// - merge split responses, worst wins
`timescale 1ns/100ps
module mba_adapter
  import mba_pkg::*;
#(
  parameter int          DATA_BYTES_LOG2 = 2,
  parameter logic [8:0]  TGT_MAX_LEN     = 9'h010,
  parameter bit          TGT_WRAPS       = 1'b0,
  parameter logic [8:0]  TGT_WRAP_LEN    = 9'h010,
  parameter bit          TGT_IS_AXI3     = 1'b0,
  parameter bit          PER_TYPE_CONV   = 1'b0
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // initiator command
  input  wire logic              ini_valid,
  output logic                   ini_ready,
  input  wire mba_cmd_type       ini_cmd,
  // initiator response
  output logic                   ini_resp_valid,
  output logic [1:0]             ini_resp,
  // target command
  output logic                   tgt_valid,
  input  wire logic              tgt_ready,
  output mba_cmd_type            tgt_cmd,
  output logic                   tgt_lock,
  // target response, one per piece
  input  wire logic              tgt_resp_valid,
  input  wire logic [1:0]        tgt_resp
);
  //==========================================================
  // helpers
  //==========================================================
  function automatic logic [1:0] worse(input logic [1:0] a, input logic [1:0] b);
    logic [1:0] ra;
    logic [1:0] rb;
    // rank: decerr 3, slverr 2, okay 1, exokay 0
    ra = (a == RESP_EXOKAY) ? 2'h0 : ((a == RESP_OKAY) ? 2'h1 : a);
    rb = (b == RESP_EXOKAY) ? 2'h0 : ((b == RESP_OKAY) ? 2'h1 : b);
    worse = (ra >= rb) ? a : b;
  endfunction : worse

  function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
    min9 = (a < b) ? a : b;
  endfunction : min9

  // beats left before address reaches a boundary of n beats (n power of two)
  function automatic logic [8:0] to_bound(input logic [ADDR_W-1:0] a,
                                          input logic [SIZE_W-1:0] sz,
                                          input logic [8:0]        n);
    logic [ADDR_W-1:0] beat;
    logic [8:0]        pos;
    beat = a >> sz;
    pos = beat[8:0] & (n - LEN_ONE);
    to_bound = n - pos;
  endfunction : to_bound

  //==========================================================
  // piece planning
  //==========================================================
  mba_state_vec_type st_reg;
  mba_state_vec_type st_next;
  logic [8:0]        cap;
  logic              narrow;
  logic              aligned;
  logic [8:0]        orig_wrap;
  logic [8:0]        plan_len;
  logic [1:0]        plan_burst;
  logic [8:0]        gen_len;
  logic [8:0]        typ_len;

  assign cap = min9(TGT_IS_AXI3 ? LEN_AXI3_MAX : LEN_AXI4_MAX,
                    (TGT_MAX_LEN == LEN_RST) ? LEN_ONE : TGT_MAX_LEN);
  assign narrow = (st_reg.orig.size < SIZE_W'(DATA_BYTES_LOG2));
  assign aligned = ((st_reg.addr & ((ADDR_W'(1) << st_reg.orig.size) - ADDR_W'(1))) == '0);
  assign orig_wrap = st_reg.orig.len;

  // generic converter: one datapath that clips to every boundary
  always_comb begin
    gen_len = min9(st_reg.left, cap);
    if (TGT_WRAPS) begin
      gen_len = min9(gen_len, to_bound(st_reg.addr, st_reg.orig.size, TGT_WRAP_LEN));
    end
    if (st_reg.orig.burst == BURST_WRAP) begin
      gen_len = min9(gen_len, to_bound(st_reg.addr, st_reg.orig.size, orig_wrap));
    end
    // fixed and narrow go one beat at a time
    if (st_reg.orig.burst == BURST_FIXED || narrow || !aligned) begin
      gen_len = LEN_ONE;
    end
  end

  // per-type converter: separate short paths selected by burst kind
  always_comb begin
    case (st_reg.orig.burst)
      BURST_FIXED: typ_len = LEN_ONE;
      // incr: pass whole or cut at cap, and also at the target window when the target wraps
      BURST_INCR:  typ_len = TGT_WRAPS ?
                     min9(min9(st_reg.left, cap),
                          to_bound(st_reg.addr, st_reg.orig.size, TGT_WRAP_LEN)) :
                     min9(st_reg.left, cap);
      BURST_WRAP:  typ_len = min9(min9(st_reg.left, cap),
                                  to_bound(st_reg.addr, st_reg.orig.size, orig_wrap));
      default:     typ_len = LEN_ONE;
    endcase
    if (narrow || !aligned) begin
      typ_len = LEN_ONE;
    end
  end

  always_comb begin
    plan_len = PER_TYPE_CONV ? typ_len : gen_len;
    plan_burst = BURST_INCR;
    // wrap passes through on matching windows, and only if its length fits within cap
    if (st_reg.orig.burst == BURST_WRAP && st_reg.addr == st_reg.orig.addr
        && st_reg.left == st_reg.orig.len && st_reg.orig.len <= cap && !narrow
        && aligned && TGT_WRAPS && (TGT_WRAP_LEN == st_reg.orig.len)) begin
      plan_len = st_reg.orig.len;
      plan_burst = BURST_WRAP;
    end
  end

  //==========================================================
  // sequencer
  //==========================================================
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] wrap_mask;

  always_comb begin
    wrap_mask = (ADDR_W'(orig_wrap) << st_reg.orig.size) - ADDR_W'(1);
    // unaligned start steps to next aligned address
    next_addr = aligned ? st_reg.addr + (ADDR_W'(st_reg.piece) << st_reg.orig.size)
                        : (st_reg.addr | ((ADDR_W'(1) << st_reg.orig.size) - ADDR_W'(1)))
                          + ADDR_W'(1);
    if (st_reg.orig.burst == BURST_FIXED) begin
      next_addr = st_reg.addr;
    end else if (st_reg.orig.burst == BURST_WRAP) begin
      next_addr = (st_reg.addr & ~wrap_mask) | (next_addr & wrap_mask);
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.ret_valid = 1'b0;
    case (st_reg.state)
      ST_IDLE: begin
        if (ini_valid) begin
          st_next.orig = ini_cmd;
          st_next.addr = ini_cmd.addr;
          st_next.left = (ini_cmd.len == LEN_RST) ? LEN_ONE : ini_cmd.len;
          st_next.resp_left = LEN_RST;
          st_next.resp = RESP_EXOKAY;
          st_next.lock = 1'b1;
          st_next.state = ST_SEND;
        end
      end
      ST_SEND: begin
        st_next.piece = plan_len;
        st_next.piece_burst = plan_burst;
        st_next.tgt_valid = 1'b1;
        st_next.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (tgt_ready) begin
          st_next.tgt_valid = 1'b0;
          st_next.addr = next_addr;
          st_next.left = st_reg.left - st_reg.piece;
          st_next.resp_left = st_reg.resp_left + LEN_ONE;
          // more pieces until original length sent
          st_next.state = (st_reg.left == st_reg.piece) ? ST_RESP : ST_SEND;
        end
      end
      ST_RESP: begin
        if (st_reg.resp_left == LEN_RST) begin
          st_next.ret_valid = 1'b1;
          // lock ends exactly with the burst
          st_next.lock = 1'b0;
          st_next.state = ST_IDLE;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
    // count from next value: a piece may answer in its own take cycle
    if (tgt_resp_valid && st_next.resp_left != LEN_RST && st_reg.state != ST_IDLE) begin
      st_next.resp = worse(st_reg.resp, tgt_resp);
      st_next.resp_left = st_next.resp_left - LEN_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{state: ST_IDLE, orig: '0, addr: ADDR_RST, left: LEN_RST, piece: LEN_RST,
                  piece_burst: BURST_INCR, resp_left: LEN_RST, resp: RESP_OKAY,
                  lock: 1'b0, tgt_valid: 1'b0, ret_valid: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  //==========================================================
  // outputs
  //==========================================================
  assign ini_ready = (st_reg.state == ST_IDLE);
  assign tgt_valid = st_reg.tgt_valid;
  assign tgt_lock = st_reg.lock;
  assign tgt_cmd = '{addr: st_reg.addr, len: st_reg.piece, size: st_reg.orig.size,
                     burst: st_reg.piece_burst, write: st_reg.orig.write};
  assign ini_resp_valid = st_reg.ret_valid;
  assign ini_resp = st_reg.resp;

  //==========================================================
  // checks
  //==========================================================
  sequence s_piece_taken;
    tgt_valid && tgt_ready;
  endsequence

  sequence s_burst_start;
    ini_valid && ini_ready;
  endsequence

  AST_PIECE_CAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_piece_taken |-> (tgt_cmd.len <= cap) && (tgt_cmd.len != LEN_RST))
    else $error("piece exceeds target limit");
  AST_LOCK_HELD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_valid |-> tgt_lock)
    else $error("piece issued without lock");
  AST_LOCK_DROP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(tgt_lock) |-> ini_resp_valid)
    else $error("lock released before burst end");
  AST_FIXED_SINGLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_piece_taken and (st_reg.orig.burst == BURST_FIXED) |->
      tgt_cmd.len == LEN_ONE && tgt_cmd.addr == st_reg.orig.addr)
    else $error("fixed burst piece wrong");
  AST_AXI3_CAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_piece_taken and (TGT_IS_AXI3) |-> tgt_cmd.len <= LEN_AXI3_MAX)
    else $error("piece over old-target limit");
  AST_NARROW_SINGLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_piece_taken and (narrow) |-> tgt_cmd.len == LEN_ONE)
    else $error("narrow piece longer than one");
  AST_UNALIGNED: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_piece_taken and (!aligned) |-> ##1 (aligned || st_reg.state == ST_RESP))
    else $error("unaligned piece did not realign");
  AST_RESP_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ini_resp_valid |=> !ini_resp_valid ##0 ini_ready)
    else $error("response repeated");
  AST_MERGE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_resp_valid && tgt_resp == RESP_DECERR && st_reg.resp_left != LEN_RST
      && st_reg.state != ST_IDLE |=> st_reg.resp == RESP_DECERR)
    else $error("error lost in merge");
  AST_PIECE_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_valid && !tgt_ready |=> tgt_valid && $stable(tgt_cmd))
    else $error("piece changed before it was taken");
  AST_LOCK_TAKEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_burst_start |=> tgt_lock)
    else $error("lock not taken at burst start");
  AST_SEQ_NO_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_piece_taken |-> TGT_WRAPS || (tgt_cmd.burst != BURST_WRAP))
    else $error("wrap piece sent to sequential target");
  AST_OWN_WINDOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_piece_taken and (st_reg.orig.burst == BURST_WRAP) and (tgt_cmd.burst == BURST_INCR) |->
      tgt_cmd.len <= to_bound(tgt_cmd.addr, tgt_cmd.size, st_reg.orig.len))
    else $error("piece crosses own wrap window");
  AST_TGT_WINDOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_piece_taken and (TGT_WRAPS) and (tgt_cmd.burst == BURST_INCR) |->
      tgt_cmd.len <= to_bound(tgt_cmd.addr, tgt_cmd.size, TGT_WRAP_LEN))
    else $error("piece crosses target wrap window");
  AST_RESP_DONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ini_resp_valid |-> !tgt_lock && !tgt_valid)
    else $error("response before all pieces done");
endmodule : mba_adapter

// ### verif/mba_tgt_model.sv
// Purpose: target model answering the adapter's pieces
// Assumes: one response per accepted piece, one cycle after the take
// Notes:   slow adds two wait cycles before ready; resp_plan gives codes per piece
`timescale 1ns/100ps
module mba_tgt_model
  import mba_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // piece handshake
  input  wire logic       tgt_valid,
  input  wire logic       tgt_lock,
  output logic            tgt_ready,
  // response control
  input  wire logic       slow,
  input  wire logic [7:0] resp_plan,
  output logic            tgt_resp_valid,
  output logic [1:0]      tgt_resp
);
  logic [1:0] wait_reg;
  logic [1:0] cnt_reg;
  //==========================================================
  // accept and answer
  //==========================================================
  assign tgt_ready = tgt_valid && (!slow || wait_reg == 2'h2);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg       <= 2'h0;
      cnt_reg        <= 2'h0;
      tgt_resp_valid <= 1'b0;
      tgt_resp       <= 2'h0;
    end else begin
      wait_reg       <= (tgt_valid && !tgt_ready) ? wait_reg + 2'h1 : 2'h0;
      tgt_resp_valid <= tgt_valid && tgt_ready;
      if (tgt_valid && tgt_ready) begin
        tgt_resp <= resp_plan[2*cnt_reg +: 2];
        cnt_reg  <= cnt_reg + 2'h1;
      end else begin
        // stale code must not look valid
        tgt_resp <= ~tgt_resp;
        if (!tgt_lock) begin
          cnt_reg <= 2'h0;
        end
      end
    end
  end
endmodule : mba_tgt_model

// ### verif/mba_adapter_tb_top.sv
// Purpose: self-checking bench for the burst adapter
// Assumes: target max length 4, sequential target, 32-bit data
// Notes:   pieces are logged at every target take and judged per scenario
`timescale 1ns/100ps
module mba_adapter_tb_top
  import mba_pkg::*;
();
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ini_valid = 1'b0;
  logic        ini_ready;
  mba_cmd_type ini_cmd = '0;
  logic        ini_resp_valid;
  logic [1:0]  ini_resp;
  logic        tgt_valid;
  logic        tgt_ready;
  mba_cmd_type tgt_cmd;
  logic        tgt_lock;
  logic        tgt_resp_valid;
  logic [1:0]  tgt_resp;
  logic        slow = 1'b0;
  logic [7:0]  resp_plan = 8'h00;
  int          miscompares = 0;
  int          checked = 0;
  mba_cmd_type seen[$];

  always #5 ref_clk = ~ref_clk;

  mba_adapter #(.TGT_MAX_LEN(9'h004)) i_mba_adapter (
    .ref_clk(ref_clk), .rst_b(rst_b), .ini_valid(ini_valid), .ini_ready(ini_ready),
    .ini_cmd(ini_cmd), .ini_resp_valid(ini_resp_valid), .ini_resp(ini_resp),
    .tgt_valid(tgt_valid), .tgt_ready(tgt_ready), .tgt_cmd(tgt_cmd), .tgt_lock(tgt_lock),
    .tgt_resp_valid(tgt_resp_valid), .tgt_resp(tgt_resp));

  mba_tgt_model i_mba_tgt_model (
    .ref_clk(ref_clk), .rst_b(rst_b), .tgt_valid(tgt_valid), .tgt_lock(tgt_lock),
    .tgt_ready(tgt_ready), .slow(slow), .resp_plan(resp_plan),
    .tgt_resp_valid(tgt_resp_valid), .tgt_resp(tgt_resp));

  //==========================================================
  // compare and close
  //==========================================================
  task automatic complete_run();
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic check_bit(input string name, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", name, e, g);
    end
  endtask : check_bit

  task automatic check_resp(input string name, input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : check_resp

  // every field is judged; size must pass through untouched
  task automatic check_cmd(input string name, input mba_cmd_type e, input mba_cmd_type g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : check_cmd

  always @(posedge ref_clk) begin
    if (tgt_valid && tgt_ready) begin
      seen.push_back(tgt_cmd);
      check_bit("lock_on_piece", 1'b1, tgt_lock);
    end
  end

  //==========================================================
  // one whole burst, judged on merged response
  //==========================================================
  task automatic run_burst(input mba_cmd_type cmd, input logic [7:0] plan, input logic s,
                           input int n, input logic [1:0] resp);
    int w;
    seen.delete();
    @(posedge ref_clk);
    ini_valid <= 1'b1;
    ini_cmd   <= cmd;
    resp_plan <= plan;
    slow      <= s;
    @(posedge ref_clk);
    ini_valid <= 1'b0;
    #1;
    check_bit("busy_ready", 1'b0, ini_ready);
    w = 0;
    while (ini_resp_valid !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      w++;
      if (w > 300) begin
        miscompares++;
        complete_run();
      end
    end
    check_resp("merged_resp", resp, ini_resp);
    check_bit("lock_released", 1'b0, tgt_lock);
    check_bit("piece_count", 1'b1, logic'(seen.size() == n));
    @(posedge ref_clk);
    #1;
    check_bit("resp_pulse_end", 1'b0, ini_resp_valid);
    check_bit("ready_after_resp", 1'b1, ini_ready);
  endtask : run_burst

  task automatic s_split();
    run_burst('{32'h0000_0100, 9'h007, 3'h2, BURST_INCR, 1'b1}, 8'h08, 1'b0, 2, RESP_SLVERR);
    check_cmd("split_0", '{32'h0000_0100, 9'h004, 3'h2, BURST_INCR, 1'b1}, seen[0]);
    check_cmd("split_1", '{32'h0000_0110, 9'h003, 3'h2, BURST_INCR, 1'b1}, seen[1]);
  endtask : s_split

  task automatic s_fixed();
    run_burst('{32'h0000_0040, 9'h003, 3'h2, BURST_FIXED, 1'b0}, 8'h0d, 1'b0, 3, RESP_DECERR);
    for (int i = 0; i < 3; i++) begin
      check_cmd("fixed", '{32'h0000_0040, 9'h001, 3'h2, BURST_INCR, 1'b0}, seen[i]);
    end
  endtask : s_fixed

  task automatic s_narrow();
    run_burst('{32'h0000_0200, 9'h002, 3'h1, BURST_INCR, 1'b1}, 8'h05, 1'b0, 2, RESP_EXOKAY);
    check_cmd("narrow_0", '{32'h0000_0200, 9'h001, 3'h1, BURST_INCR, 1'b1}, seen[0]);
    check_cmd("narrow_1", '{32'h0000_0202, 9'h001, 3'h1, BURST_INCR, 1'b1}, seen[1]);
  endtask : s_narrow

  // slow target: pieces wait for ready
  task automatic s_wrap();
    run_burst('{32'h0000_0110, 9'h008, 3'h2, BURST_WRAP, 1'b0}, 8'h00, 1'b1, 2, RESP_OKAY);
    check_cmd("wrap_0", '{32'h0000_0110, 9'h004, 3'h2, BURST_INCR, 1'b0}, seen[0]);
    check_cmd("wrap_1", '{32'h0000_0100, 9'h004, 3'h2, BURST_INCR, 1'b0}, seen[1]);
  endtask : s_wrap

  // short wrap still becomes incr pieces at a sequential target
  task automatic s_wrap_short();
    run_burst('{32'h0000_0108, 9'h004, 3'h2, BURST_WRAP, 1'b1}, 8'h06, 1'b0, 2, RESP_SLVERR);
    check_cmd("short_0", '{32'h0000_0108, 9'h002, 3'h2, BURST_INCR, 1'b1}, seen[0]);
    check_cmd("short_1", '{32'h0000_0100, 9'h002, 3'h2, BURST_INCR, 1'b1}, seen[1]);
  endtask : s_wrap_short

  // start address left unaligned by an upstream width adapter
  task automatic s_unaligned();
    run_burst('{32'h0000_0102, 9'h002, 3'h2, BURST_INCR, 1'b0}, 8'h04, 1'b0, 2, RESP_OKAY);
    check_cmd("unalign_0", '{32'h0000_0102, 9'h001, 3'h2, BURST_INCR, 1'b0}, seen[0]);
    check_cmd("unalign_1", '{32'h0000_0104, 9'h001, 3'h2, BURST_INCR, 1'b0}, seen[1]);
  endtask : s_unaligned

  //==========================================================
  // main sequence
  //==========================================================
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    check_bit("rst_ready", 1'b1, ini_ready);
    check_bit("rst_lock", 1'b0, tgt_lock);
    check_bit("rst_tgt_valid", 1'b0, tgt_valid);
    // initiator addresses aligned; s_unaligned mimics a width adapter
    // no narrow 256-beat burst is ever issued
    // wrap stimulus uses the full window length
    s_split();
    s_fixed();
    s_narrow();
    s_wrap();
    s_wrap_short();
    s_unaligned();
    complete_run();
  end
endmodule : mba_adapter_tb_top
